// file: core/hsc_pkg.sv
// package for the high-speed counter input allocation block
// assumes one 40 MHz bus clock and an AHB-Lite master in front of the registers
package hsc_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int HSC_NUM_INPUTS  = 8;
    localparam int HSC_NUM_CNT     = 21;
    localparam int HSC_NUM_DIRSEL  = 11;
    localparam int HSC_CNT_WIDTH   = 32;
    localparam int HSC_FILT_CNT_W  = 11;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int HSC_CLK_PERIOD_NS = 25;
    localparam int HSC_FILT_FAST_NS  = 5000;
    localparam int HSC_FILT_SLOW_NS  = 50000;
    localparam int HSC_FILT_FAST_CYC = (HSC_FILT_FAST_NS + HSC_CLK_PERIOD_NS - 1) / HSC_CLK_PERIOD_NS;
    localparam int HSC_FILT_SLOW_CYC = (HSC_FILT_SLOW_NS + HSC_CLK_PERIOD_NS - 1) / HSC_CLK_PERIOD_NS;
    localparam int HSC_FAST_INPUTS   = 6;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] HSC_OFF_CTRL     = 8'h00;
    localparam logic [7:0] HSC_OFF_ENABLE   = 8'h04;
    localparam logic [7:0] HSC_OFF_DIRSEL   = 8'h08;
    localparam logic [7:0] HSC_OFF_OTHERUSE = 8'h0c;
    localparam logic [7:0] HSC_OFF_INPUTS   = 8'h10;
    localparam logic [7:0] HSC_OFF_DIRMON   = 8'h14;
    localparam logic [7:0] HSC_OFF_HWSTAT   = 8'h18;
    localparam logic [7:0] HSC_OFF_CONFLICT = 8'h1c;
    localparam logic [7:0] HSC_OFF_CNT_BASE = 8'h80;

    // ----------------------------------------------------------------
    // control register fields and reset values
    // ----------------------------------------------------------------
    localparam int HSC_CTRL_FC       = 0;
    localparam int HSC_CTRL_POL      = 1;
    localparam int HSC_CTRL_SW_A     = 2;
    localparam int HSC_CTRL_SW_B     = 3;
    localparam int HSC_CTRL_SW_DQ    = 4;
    localparam int HSC_CTRL_EDGE_LO  = 5;
    localparam int HSC_CTRL_EDGE_HI  = 6;
    localparam int HSC_CTRL_CMP_LO   = 7;
    localparam int HSC_CTRL_CMP_HI   = 10;
    localparam int HSC_CTRL_W        = 11;
    localparam logic [HSC_CTRL_W-1:0]     HSC_CTRL_RST   = 11'h000;
    localparam logic [HSC_NUM_CNT-1:0]    HSC_ENABLE_RST = 21'h000000;
    localparam logic [HSC_NUM_DIRSEL-1:0] HSC_DIRSEL_RST = 11'h000;
    localparam logic [HSC_NUM_INPUTS-1:0] HSC_OTHER_RST  = 8'h00;

    // ----------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] HSC_HTRANS_NONSEQ = 2'h2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HSC_KIND_SINGLE = 2'h0,
        HSC_KIND_DUAL   = 2'h1,
        HSC_KIND_QUAD   = 2'h2
    } hsc_kind_t;

    typedef struct packed {
        hsc_kind_t  kind;
        logic [2:0] a;
        logic [2:0] b;
        logic       r_en;
        logic [2:0] r;
        logic       s_en;
        logic [2:0] s;
        logic       hw;
    } hsc_map_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
    } hsc_ahb_req_t;

endpackage

// file: core/hsc_input_alloc.sv
// high-speed counter bank with input allocation, filters and function switching
// assumes an AHB-Lite master on hclk and pulse inputs asynchronous to hclk
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module hsc_input_alloc #(
    parameter int CNT_WIDTH = hsc_pkg::HSC_CNT_WIDTH
) (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire hsc_pkg::hsc_ahb_req_t ahb_req,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // pulse inputs and general input levels
    input  wire logic [7:0]            pulse_input,
    output logic      [7:0]            general_input
);
    import hsc_pkg::*;

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (CNT_WIDTH != HSC_CNT_WIDTH) begin : g_bad_width
        $error("counter width must be 32");
    end

    // ----------------------------------------------------------------
    // routing table
    // ----------------------------------------------------------------
    function automatic hsc_map_t cnt_map(input logic [4:0] c, input logic op_a,
                                         input logic op_b, input logic op_dq);
        hsc_map_t m;
        m = '{kind: HSC_KIND_SINGLE, a: 3'h0, b: 3'h0, r_en: 1'b0, r: 3'h0,
              s_en: 1'b0, s: 3'h0, hw: 1'b0};
        case (c)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
                m.a  = c[2:0];
                m.hw = 1'b1;
            end
            5'h06: begin m.a = 3'h0; m.r_en = 1'b1; m.r = 3'h1; end
            5'h07: begin m.a = 3'h2; m.r_en = 1'b1; m.r = 3'h3; end
            5'h08: begin m.a = 3'h4; m.r_en = 1'b1; m.r = 3'h5; end
            5'h09: begin
                if (op_a) begin
                    m.a  = 3'h6;
                    m.hw = 1'b1;
                end else begin
                    m.a = 3'h0; m.r_en = 1'b1; m.r = 3'h1; m.s_en = 1'b1; m.s = 3'h6;
                end
            end
            5'h0a: begin
                if (op_b) begin
                    m.a  = 3'h7;
                    m.hw = 1'b1;
                end else begin
                    m.a = 3'h2; m.r_en = 1'b1; m.r = 3'h3; m.s_en = 1'b1; m.s = 3'h7;
                end
            end
            5'h0b, 5'h0c, 5'h0e: begin
                m.kind = HSC_KIND_DUAL;
                m.a    = 3'h0;
                m.b    = 3'h1;
                m.hw   = (c == 5'h0b);
                m.r_en = (c != 5'h0b);
                m.r    = 3'h2;
                m.s_en = (c == 5'h0e);
                m.s    = 3'h6;
            end
            5'h0d, 5'h0f: begin
                m.kind = HSC_KIND_DUAL;
                m.a    = 3'h3;
                m.b    = 3'h4;
                m.hw   = (c == 5'h0d) && op_dq;
                m.r_en = !((c == 5'h0d) && op_dq);
                m.r    = 3'h5;
                m.s_en = (c == 5'h0f);
                m.s    = 3'h7;
            end
            5'h10, 5'h11, 5'h13: begin
                m.kind = HSC_KIND_QUAD;
                m.a    = 3'h0;
                m.b    = 3'h1;
                m.hw   = (c == 5'h10);
                m.r_en = (c != 5'h10);
                m.r    = 3'h2;
                m.s_en = (c == 5'h13);
                m.s    = 3'h6;
            end
            5'h12, 5'h14: begin
                m.kind = HSC_KIND_QUAD;
                m.a    = 3'h3;
                m.b    = 3'h4;
                m.hw   = (c == 5'h12) && !op_dq;
                m.r_en = !((c == 5'h12) && op_dq);
                m.r    = 3'h5;
                m.s_en = (c == 5'h14);
                m.s    = 3'h7;
            end
            default: m.a = 3'h0;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] claim_of(input hsc_map_t m);
        logic [7:0] v;
        v = 8'h00;
        v[m.a] = 1'b1;
        if (m.kind != HSC_KIND_SINGLE) v[m.b] = 1'b1;
        if (m.r_en) v[m.r] = 1'b1;
        if (m.s_en) v[m.s] = 1'b1;
        return v;
    endfunction

    function automatic logic [HSC_FILT_CNT_W-1:0] filt_limit(input int i);
        return (i < HSC_FAST_INPUTS) ? HSC_FILT_CNT_W'(HSC_FILT_FAST_CYC - 1)
                                     : HSC_FILT_CNT_W'(HSC_FILT_SLOW_CYC - 1);
    endfunction

    // ----------------------------------------------------------------
    // software-visible state
    // ----------------------------------------------------------------
    logic [HSC_CTRL_W-1:0]     ctrl_reg;
    logic [HSC_NUM_CNT-1:0]    enable_reg;
    logic [HSC_NUM_DIRSEL-1:0] dirsel_reg;
    logic [HSC_NUM_INPUTS-1:0] other_reg;
    logic                      wr_pend_reg;
    logic [7:0]                wr_addr_reg;

    wire fc      = ctrl_reg[HSC_CTRL_FC];
    wire pol_inv = fc && ctrl_reg[HSC_CTRL_POL];
    wire op_a    = fc && ctrl_reg[HSC_CTRL_SW_A];
    wire op_b    = fc && ctrl_reg[HSC_CTRL_SW_B];
    wire op_dq   = fc && ctrl_reg[HSC_CTRL_SW_DQ];
    wire edge_lo = fc && ctrl_reg[HSC_CTRL_EDGE_LO];
    wire edge_hi = fc && ctrl_reg[HSC_CTRL_EDGE_HI];
    wire cmp_any = |ctrl_reg[HSC_CTRL_CMP_HI:HSC_CTRL_CMP_LO];

    // ----------------------------------------------------------------
    // input synchronisers and filters
    // ----------------------------------------------------------------
    logic [7:0]                sync1_reg;
    logic [7:0]                sync2_reg;
    logic [7:0]                filt_reg;
    logic [7:0]                prev_reg;
    logic [HSC_FILT_CNT_W-1:0] fcnt_reg [HSC_NUM_INPUTS];
    logic [7:0]                claimed;
    logic [7:0]                conflict;
    hsc_map_t                  map      [HSC_NUM_CNT];

    always_comb begin
        logic [7:0] seen;
        seen     = 8'h00;
        claimed  = 8'h00;
        conflict = 8'h00;
        for (int c = 0; c < HSC_NUM_CNT; c++) begin
            if (enable_reg[c]) begin
                conflict = conflict | (claimed & claim_of(map[c]));
                claimed  = claimed | claim_of(map[c]);
            end
        end
        seen     = claimed & other_reg;
        conflict = conflict | seen;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= pulse_input;
            sync2_reg <= sync1_reg;
        end
    end

    // a claimed input only moves after staying put for the whole filter time
    for (genvar i = 0; i < HSC_NUM_INPUTS; i++) begin : g_filt
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                fcnt_reg[i] <= '0;
                filt_reg[i] <= 1'b0;
            end else if (!claimed[i] || sync2_reg[i] == filt_reg[i]) begin
                fcnt_reg[i] <= '0;
                filt_reg[i] <= sync2_reg[i];
            end else if (fcnt_reg[i] == filt_limit(i)) begin
                fcnt_reg[i] <= '0;
                filt_reg[i] <= sync2_reg[i];
            end else begin
                fcnt_reg[i] <= fcnt_reg[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg      <= 8'h00;
            general_input <= 8'h00;
        end else begin
            prev_reg      <= filt_reg;
            general_input <= filt_reg;
        end
    end

    wire [7:0] rise = filt_reg & ~prev_reg;
    wire [7:0] fall = ~filt_reg & prev_reg;

    // ----------------------------------------------------------------
    // counter bank
    // ----------------------------------------------------------------
    logic [CNT_WIDTH-1:0]   cnt_val [HSC_NUM_CNT];
    logic [HSC_NUM_CNT-1:0] hw_stat;
    logic [HSC_NUM_CNT-1:0] dir_mon;
    wire                    wr_cnt   = wr_pend_reg && wr_addr_reg >= HSC_OFF_CNT_BASE;
    wire [7:0]              wr_index = 8'(wr_addr_reg - HSC_OFF_CNT_BASE) >> 2;

    for (genvar c = 0; c < HSC_NUM_CNT; c++) begin : g_cnt
        logic [CNT_WIDTH-1:0] value_reg;
        logic                 down_reg;
        logic                 up;
        logic                 down;
        logic                 four_edge;
        logic [1:0]           code_now;
        logic [1:0]           code_old;
        logic [1:0]           step;
        logic                 run;
        logic                 clr;
        logic                 soft_wr;

        assign map[c]    = cnt_map(5'(c), op_a, op_b, op_dq);
        assign four_edge = (map[c].b == 3'h4) ? edge_hi : edge_lo;
        assign code_now  = {filt_reg[map[c].b], filt_reg[map[c].a] ^ filt_reg[map[c].b]};
        assign code_old  = {prev_reg[map[c].b], prev_reg[map[c].a] ^ prev_reg[map[c].b]};
        assign step      = code_now - code_old;
        assign run       = enable_reg[c] && (!map[c].s_en || filt_reg[map[c].s]);
        assign clr       = map[c].r_en && (pol_inv ? fall[map[c].r] : rise[map[c].r]);
        assign soft_wr   = wr_cnt && wr_index == 8'(c);

        always_comb begin
            up   = 1'b0;
            down = 1'b0;
            case (map[c].kind)
                HSC_KIND_SINGLE: begin
                    up   = rise[map[c].a] && !((c < HSC_NUM_DIRSEL) && dirsel_reg[c]);
                    down = rise[map[c].a] && (c < HSC_NUM_DIRSEL) && dirsel_reg[c];
                end
                HSC_KIND_DUAL: begin
                    up   = rise[map[c].a] && !rise[map[c].b];
                    down = rise[map[c].b] && !rise[map[c].a];
                end
                HSC_KIND_QUAD: begin
                    if (four_edge) begin
                        up   = (step == 2'h1);
                        down = (step == 2'h3);
                    end else begin
                        up   = rise[map[c].a] && !filt_reg[map[c].b];
                        down = fall[map[c].a] && !filt_reg[map[c].b];
                    end
                end
                default: begin
                    up   = 1'b0;
                    down = 1'b0;
                end
            endcase
        end

        // external reset outranks a bus preset, which outranks a count step
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                value_reg <= '0;
                down_reg  <= 1'b0;
            end else begin
                if (run && clr) value_reg <= '0;
                else if (soft_wr) value_reg <= hwdata[CNT_WIDTH-1:0];
                else if (run && up) value_reg <= value_reg + 1'b1;
                else if (run && down) value_reg <= value_reg - 1'b1;
                if (run && down) down_reg <= 1'b1;
                else if (run && up) down_reg <= 1'b0;
            end
        end

        assign cnt_val[c] = value_reg;
        assign dir_mon[c] = (map[c].kind != HSC_KIND_SINGLE) && down_reg;
        assign hw_stat[c] = map[c].hw && !cmp_any && !((c == 18) && pol_inv);
    end

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    wire        take     = ahb_req.hsel && hready && ahb_req.htrans == HSC_HTRANS_NONSEQ;
    wire        in_range = ahb_req.haddr[31:8] == 24'h000000;
    wire [7:0]  rd_off   = {ahb_req.haddr[7:2], 2'h0};
    wire [7:0]  rd_index = 8'(rd_off - HSC_OFF_CNT_BASE) >> 2;
    logic [31:0] rd_data;

    always_comb begin
        rd_data = 32'h00000000;
        case (rd_off)
            HSC_OFF_CTRL:     rd_data = 32'(ctrl_reg);
            HSC_OFF_ENABLE:   rd_data = 32'(enable_reg);
            HSC_OFF_DIRSEL:   rd_data = 32'(dirsel_reg);
            HSC_OFF_OTHERUSE: rd_data = 32'(other_reg);
            HSC_OFF_INPUTS:   rd_data = {16'h0000, claimed, filt_reg};
            HSC_OFF_DIRMON:   rd_data = 32'(dir_mon);
            HSC_OFF_HWSTAT:   rd_data = 32'(hw_stat);
            HSC_OFF_CONFLICT: rd_data = 32'(conflict);
            default: begin
                if (rd_off >= HSC_OFF_CNT_BASE && rd_index < 8'(HSC_NUM_CNT))
                    rd_data = 32'(cnt_val[rd_index[4:0]]);
            end
        endcase
        if (!in_range) rd_data = 32'h00000000;
    end

    // zero wait states; an address outside the map reads zero and drops writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b0;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= take && ahb_req.hwrite && in_range;
            wr_addr_reg <= rd_off;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            if (take && !ahb_req.hwrite) hrdata <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg   <= HSC_CTRL_RST;
            enable_reg <= HSC_ENABLE_RST;
            dirsel_reg <= HSC_DIRSEL_RST;
            other_reg  <= HSC_OTHER_RST;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                HSC_OFF_CTRL:     ctrl_reg   <= hwdata[HSC_CTRL_W-1:0];
                HSC_OFF_ENABLE:   enable_reg <= hwdata[HSC_NUM_CNT-1:0];
                HSC_OFF_DIRSEL:   dirsel_reg <= hwdata[HSC_NUM_DIRSEL-1:0];
                HSC_OFF_OTHERUSE: other_reg  <= hwdata[HSC_NUM_INPUTS-1:0];
                default:          ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: sim/hsc_input_alloc_sva.sv
// checker for the counter bank bus reads and input levels
// assumes hready is tied to hreadyout and every transfer is one word
`timescale 1ns/1ps
`default_nettype none
module hsc_input_alloc_chk (
    // clock and reset
    input wire logic                  hclk,
    input wire logic                  hresetn,
    // bus
    input wire hsc_pkg::hsc_ahb_req_t ahb_req,
    input wire logic                  hready,
    input wire logic [31:0]           hwdata,
    input wire logic [31:0]           hrdata,
    // pins
    input wire logic [7:0]            pulse_input,
    input wire logic [7:0]            general_input
);
    import hsc_pkg::*;
    // --------------------------------------------------------------
    // snooped control state
    // --------------------------------------------------------------
    // the relays are tracked from the bus, so preset writes are not modelled
    wire        tk = ahb_req.hsel && hready && ahb_req.htrans == HSC_HTRANS_NONSEQ;
    wire        hi = ahb_req.haddr[31:8] != 24'h0;
    wire [7:0]  ofs = ahb_req.haddr[7:0];
    wire        rd_ok = tk && !ahb_req.hwrite && !hi;
    wire        rd_hw = rd_ok && ofs == HSC_OFF_HWSTAT;
    wire        rd_in = rd_ok && ofs == HSC_OFF_INPUTS;
    logic       wv_q;
    logic [7:0] wa_q;
    logic [10:0] ctrl_q;
    logic [20:0] en_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wv_q   <= 1'b0;
            wa_q   <= 8'h00;
            ctrl_q <= 11'h000;
            en_q   <= 21'h000000;
        end else begin
            wv_q <= tk && ahb_req.hwrite && !hi;
            wa_q <= ofs;
            if (wv_q && wa_q == HSC_OFF_CTRL) ctrl_q <= hwdata[10:0];
            if (wv_q && wa_q == HSC_OFF_ENABLE) en_q <= hwdata[20:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_soft(logic c, logic [20:0] m);
        rd_hw && c |=> (hrdata[20:0] & m) == 21'h0;
    endproperty
    chk_cmp_soft: assert property (p_soft(|ctrl_q[10:7], 21'h1fffff))
        else $error("hardware flag while a compare is in use");
    chk_pol_soft: assert property (p_soft(ctrl_q[0] && ctrl_q[1], 21'h040000))
        else $error("inverted reset left quadrature in hardware");
    chk_opt_soft: assert property (p_soft(ctrl_q[0] && ctrl_q[4], 21'h040000))
        else $error("reset-less quadrature left in hardware");
    chk_default_soft: assert property (p_soft(!ctrl_q[0], 21'h002600))
        else $error("switchable counter in hardware without relay");
    chk_single_map: assert property (rd_in && en_q[20:6] == 15'h0
        |=> hrdata[15:8] == {2'b00, $past(en_q[5:0])}) else $error("single input claim wrong");
    chk_pair_map: assert property (rd_in && (en_q == 21'h000800 || en_q == 21'h010000)
        |=> hrdata[15:8] == 8'h03) else $error("pair claim wrong");
    chk_shared_flag: assert property (rd_ok && ofs == HSC_OFF_CONFLICT && en_q[0] && en_q[16]
        |=> hrdata[0]) else $error("shared input not flagged");
    chk_level_follow: assert property (((general_input ^ $past(general_input))
        & (general_input ^ $past(pulse_input, 2)) & (general_input ^ $past(pulse_input, 3))
        & (general_input ^ $past(pulse_input, 4))) == 8'h00) else $error("level without cause");
    cover property (rd_hw && |ctrl_q[10:7]);
    cover property (rd_in && en_q == 21'h010000);
    cover property ($changed(general_input));
endmodule
bind hsc_input_alloc hsc_input_alloc_chk i_hsc_input_alloc_chk (.hclk(hclk),
    .hresetn(hresetn), .ahb_req(ahb_req), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .pulse_input(pulse_input), .general_input(general_input));
`default_nettype wire

// file: sim/hsc_pulse_src.sv
// open-collector pulse source: plain pulses and encoder phases
// assumes the bench calls its tasks one at a time; a released line reads off
`timescale 1ns/1ps
`default_nettype none
module hsc_pulse_src (
    // clock
    input wire logic  hclk,
    // lines towards the counter inputs
    output logic [7:0] pins
);
    logic [7:0] on_q = 8'h00;
    // a released collector leaves the input off, so the level is the on bits
    assign pins = on_q;
    // one on/off pulse, each level held for hold cycles
    task automatic pulse(input int ch, input int hold);
        @(posedge hclk) on_q[ch] <= 1'b1;
        repeat (hold) @(posedge hclk);
        on_q[ch] <= 1'b0;
        repeat (hold) @(posedge hclk);
    endtask
    // one gray cycle on lines a and a+1, phase a leads when counting up
    task automatic quad(input int a, input bit up, input int hold);
        logic [7:0] s;
        s = up ? 8'h78 : 8'hb4;
        for (int i = 3; i >= 0; i--) begin
            on_q[a+:2] <= s[2*i+:2];
            repeat (hold) @(posedge hclk);
        end
    endtask
endmodule
`default_nettype wire

// file: sim/hsc_input_alloc_test.sv
// self-checking bench for the counter input allocation block
// assumes the pulse source model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
module hsc_input_alloc_test;
    import hsc_pkg::*;
    logic         hclk = 1'b0;
    logic         hresetn = 1'b0;
    hsc_ahb_req_t ahb_req = '0;
    logic [31:0]  hwdata = 32'h0;
    logic [31:0]  rv;
    wire  [31:0]  hrdata;
    wire          hreadyout;
    wire          hresp;
    wire  [7:0]   pins;
    wire  [7:0]   general_input;
    int           miscompares = 0;
    int           checks_done = 0;
    int           seed = 32'h2cae;
    int           n;
    always #12.5 hclk = ~hclk;
    hsc_input_alloc i_hsc_input_alloc (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pulse_input(pins), .general_input(general_input));
    hsc_pulse_src i_hsc_pulse_src (.hclk(hclk), .pins(pins));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] quad_steps(input int cyc, input bit four);
        return cyc * (four ? 4 : 1);
    endfunction
    function automatic logic [31:0] cnt(input int i);
        return 32'(HSC_OFF_CNT_BASE) + 32'(4 * i);
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one single transfer; the master waits on hready for both phases
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        ahb_req <= '{1'b1, a, HSC_HTRANS_NONSEQ, w, 3'h2};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        ahb_req <= '0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        check(what, exp, rv);
        check("response", 32'h0, {31'h0, hresp});
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(25 * 60000);
        miscompares++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 24; i += 4) rd(i, 32'h0, "reset value");
        rd(cnt(0), 32'h0, "reset count");
        rd(($random(seed) & 32'hfffffffc) | 32'h100, 32'h0, "out of range");
        $display("test reset values done");
        wr(HSC_OFF_ENABLE, 32'h1);
        rd(HSC_OFF_INPUTS, 32'h100, "claimed inputs");
        n = 2 + ($random(seed) & 3);
        repeat (n) i_hsc_pulse_src.pulse(0, 240);
        i_hsc_pulse_src.pulse(0, 100);
        rd(cnt(0), n, "up count");
        fork
            i_hsc_pulse_src.pulse(2, 20);
            begin
                repeat (10) @(posedge hclk);
                check("free input", 32'h4, 32'(general_input));
            end
        join
        wr(cnt(0), 32'h0);
        wr(HSC_OFF_DIRSEL, 32'h1);
        i_hsc_pulse_src.pulse(0, 240);
        rd(cnt(0), 32'hffffffff, "down wrap");
        $display("test single input done");
        // only the quadrature counter claims inputs 0 and 1 here
        wr(HSC_OFF_ENABLE, 32'h1 << 16);
        rd(HSC_OFF_INPUTS, 32'h300, "quadrature claim");
        repeat (2) i_hsc_pulse_src.quad(0, 1'b1, 220);
        rd(cnt(16), quad_steps(2, 0), "1-edge up");
        rd(HSC_OFF_DIRMON, 32'h0, "monitor up");
        i_hsc_pulse_src.quad(0, 1'b0, 220);
        rd(cnt(16), quad_steps(1, 0), "1-edge down");
        rd(HSC_OFF_DIRMON, 32'h1 << 16, "monitor down");
        wr(HSC_OFF_CTRL, 32'h21);
        i_hsc_pulse_src.quad(0, 1'b1, 220);
        rd(cnt(16), 1 + quad_steps(1, 1), "4-edge up");
        $display("test quadrature done");
        wr(HSC_OFF_CTRL, 32'h0);
        wr(HSC_OFF_ENABLE, (32'h1 << 9) | (32'h1 << 18));
        // hardware status covers every counter, enabled or not
        rd(HSC_OFF_HWSTAT, 32'h5083f, "default handling");
        wr(HSC_OFF_CTRL, 32'h05);
        rd(HSC_OFF_HWSTAT, 32'h50a3f, "switched handling");
        rd(HSC_OFF_INPUTS, 32'h7800, "switched claim");
        i_hsc_pulse_src.pulse(6, 1000);
        i_hsc_pulse_src.pulse(6, 2100);
        rd(cnt(9), 32'h1, "slow filter");
        wr(HSC_OFF_CTRL, 32'h85);
        rd(HSC_OFF_HWSTAT, 32'h0, "compare in use");
        wr(HSC_OFF_CTRL, 32'h03);
        rd(HSC_OFF_HWSTAT, 32'h1083f, "inverted reset");
        wr(HSC_OFF_CTRL, 32'h11);
        rd(HSC_OFF_HWSTAT, 32'h1283f, "reset-less variant");
        rd(HSC_OFF_INPUTS, 32'h5b00, "software claim");
        $display("test switching done");
        wr(HSC_OFF_CTRL, 32'h0);
        wr(HSC_OFF_ENABLE, 32'h1 << 6);
        i_hsc_pulse_src.pulse(0, 240);
        rd(cnt(6), 32'h1, "reset counter count");
        i_hsc_pulse_src.pulse(1, 240);
        rd(cnt(6), 32'h0, "external reset");
        wr(HSC_OFF_ENABLE, 32'h10001);
        wr(HSC_OFF_OTHERUSE, 32'h82);
        rd(HSC_OFF_CONFLICT, 32'h3, "shared inputs");
        $display("test shared inputs done");
        print_verdict;
    end
endmodule
`default_nettype wire
